// ==== verilog/uswm_master.v ====
/*
 * serial-port style bus master: register file, baud generator,
 * transmitter with a two-entry holding buffer, receiver that samples
 * the bus, and open-drain bus pin driver.
 * assumes: host bus synchronous to sys_clk_in, bus pin pulled up
 * externally, bus input asynchronous.
 */
`timescale 1ns/1ps
`include "uswm_map.vh"

// Functional notes
// - bus reset: divisor for about 10473 baud, 8-bit chars, send F0
// - reset char gives five 95.5 us periods low, five high
// - readback F0 means no slave; any upper zero means presence
// - slot divisor 1, 6-bit char gives eight 8.68 us periods
// - character 00 writes zero, FF writes one
// - every received character must be read, even when discarded
// - bus bit read by write-one slot, taken from received lsb
// - length bits both one for 8-bit, low only for 6-bit
// - 8-bit chars allowed for slots, adding 17.36 us each
// - divisor access bit maps offsets 0 and 1 onto the divisor
// - ttl drive high pulls bus low; idle drive low
// - ttl write-one/read pulse high between 1 and 15 us
// - ttl write-zero pulse 60 us; returned data uninverted
// - 5v port adapter: no software inversion either way
// - dtr held asserted to power pull-up and receive inverter
// - bytes split into bit characters lsb first, reassembled likewise
// - receiver starts on falling edge, ignores bits past character
module uswm_master (
    input  wire       sys_clk_in,
    input  wire       sys_rst_in,
    input  wire [2:0] reg_addr_in,
    input  wire [7:0] reg_wdata_in,
    input  wire       reg_wr_in,
    input  wire       reg_rd_in,
    output reg  [7:0] reg_rdata_out,
    output wire       tx_ready_out,
    input  wire       bus_in,
    output wire       bus_out,
    output wire       bus_oe_out,
    output reg        ttl_drive_out,
    output reg        term_ready_out,
    output reg        req_send_out,
    output reg        aux_output_one_out,
    output reg        aux_output_two_out
);
    // 40 MHz / 1.8432 MHz reference, fixed-point phase accumulator
    localparam [15:0] REF_STEP = 16'd3020; // 1843200*65536/40e6
    localparam        ST_IDLE  = 4'b0001;
    localparam        ST_START = 4'b0010;
    localparam        ST_DATA  = 4'b0100;
    localparam        ST_STOP  = 4'b1000;

    reg  [7:0]  lcr_q;
    reg  [7:0]  mcr_q;
    reg  [3:0]  ier_q;
    reg  [15:0] div_q;
    reg  [16:0] ref_acc_q;
    reg  [15:0] baud_cnt_q;
    reg         tick_q;
    // two-entry holding buffer
    reg  [7:0]  buf_q [0:1];
    reg         wp_q;
    reg         rp_q;
    reg  [1:0]  cnt_q;
    // transmitter
    reg  [3:0]  tx_st_q;
    reg  [3:0]  tx_ovs_q;
    reg  [2:0]  tx_bit_q;
    reg  [7:0]  tx_sh_q;
    reg         tx_line_q;
    // receiver
    reg         rx_s1_q;
    reg         rx_s2_q;
    reg         rx_prev_q;
    reg  [3:0]  rx_st_q;
    reg  [3:0]  rx_ovs_q;
    reg  [2:0]  rx_bit_q;
    reg  [7:0]  rx_sh_q;
    reg  [7:0]  rbr_q;
    reg         dr_q;
    reg         oe_q;
    reg         fe_q;

    // index of last data bit for the length field
    // 8-bit length also serves slots
    function [2:0] char_last;
        input [1:0] len;
        begin
            char_last = {1'b1, len}; // 5..8 bits -> 4..7
        end
    endfunction

    wire        div_acc  = lcr_q[`USWM_LCR_DIV_ACC];
    wire        loop_en  = mcr_q[`USWM_MCR_LOOP];
    wire        rx_line  = loop_en ? tx_line_q : rx_s2_q;
    wire        buf_push = reg_wr_in && !div_acc && reg_addr_in == `USWM_OFS_DATA;
    wire        rbr_rd   = reg_rd_in && !div_acc && reg_addr_in == `USWM_OFS_DATA;
    wire        lsr_rd   = reg_rd_in && reg_addr_in == `USWM_OFS_LSR;
    wire        tx_take  = tick_q && tx_st_q == ST_IDLE && cnt_q != 2'd0;
    wire        rx_done;
    wire [2:0]  last_bit = char_last(lcr_q[1:0]);

    // buffer ready: refuses writes when both entries hold a char
    assign tx_ready_out = cnt_q != 2'd2;

    // drive high pulls bus low, idle low
    assign bus_out    = 1'b0;
    assign bus_oe_out = ~tx_line_q & ~loop_en;

    // baud generator: reference clock then divisor, x16 oversample tick
    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            ref_acc_q  <= 17'h00000;
            baud_cnt_q <= 16'h0000;
            tick_q     <= 1'b0;
        end else begin
            ref_acc_q <= {1'b0, ref_acc_q[15:0]} + {1'b0, REF_STEP};
            tick_q    <= 1'b0;
            if (ref_acc_q[16]) begin
                if (baud_cnt_q + 16'h0001 >= div_q) begin
                    baud_cnt_q <= 16'h0000;
                    tick_q     <= 1'b1;
                end else begin
                    baud_cnt_q <= baud_cnt_q + 16'h0001;
                end
            end
        end
    end

    // register writes
    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            lcr_q <= `USWM_RST_LCR;
            mcr_q <= `USWM_RST_MCR;
            ier_q <= 4'h0;
            div_q <= `USWM_RST_DIV;
        end else if (reg_wr_in) begin
            case (reg_addr_in)
                `USWM_OFS_DATA: if (div_acc) div_q[7:0] <= reg_wdata_in;
                `USWM_OFS_IER: begin
                    if (div_acc)
                        div_q[15:8] <= reg_wdata_in;
                    else
                        ier_q <= reg_wdata_in[3:0];
                end
                `USWM_OFS_LCR: lcr_q <= reg_wdata_in;
                `USWM_OFS_MCR: mcr_q <= {3'h0, reg_wdata_in[4:0]};
                default: ;
            endcase
        end
    end

    // holding buffer push / pop
    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            wp_q  <= 1'b0;
            rp_q  <= 1'b0;
            cnt_q <= 2'd0;
        end else begin
            if (buf_push && tx_ready_out) begin
                buf_q[wp_q] <= reg_wdata_in;
                wp_q        <= ~wp_q;
            end
            if (tx_take)
                rp_q <= ~rp_q;
            case ({buf_push && tx_ready_out, tx_take})
                2'b10:   cnt_q <= cnt_q + 2'd1;
                2'b01:   cnt_q <= cnt_q - 2'd1;
                default: cnt_q <= cnt_q;
            endcase
        end
    end

    // transmitter: start low, data lsb first, one stop high
    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            tx_st_q   <= ST_IDLE;
            tx_ovs_q  <= 4'h0;
            tx_bit_q  <= 3'd0;
            tx_sh_q   <= 8'h00;
            tx_line_q <= 1'b1;
        end else if (tick_q) begin
            tx_ovs_q <= tx_ovs_q + 4'h1;
            case (tx_st_q)
                ST_IDLE: begin
                    tx_ovs_q  <= 4'h0;
                    tx_line_q <= 1'b1;
                    if (cnt_q != 2'd0) begin
                        // char 00 / FF form slot shape
                        tx_sh_q   <= buf_q[rp_q];
                        tx_line_q <= 1'b0;
                        tx_st_q   <= ST_START;
                    end
                end
                ST_START: if (tx_ovs_q == 4'hF) begin
                    // start plus data bits at bit period
                    tx_line_q <= tx_sh_q[0];
                    tx_sh_q   <= {1'b1, tx_sh_q[7:1]};
                    tx_bit_q  <= 3'd0;
                    tx_st_q   <= ST_DATA;
                end
                ST_DATA: if (tx_ovs_q == 4'hF) begin
                    if (tx_bit_q == last_bit) begin
                        tx_line_q <= 1'b1;
                        tx_st_q   <= ST_STOP;
                    end else begin
                        tx_line_q <= tx_sh_q[0];
                        tx_sh_q   <= {1'b1, tx_sh_q[7:1]};
                        tx_bit_q  <= tx_bit_q + 3'd1;
                    end
                end
                ST_STOP: if (tx_ovs_q == 4'hF)
                    tx_st_q <= ST_IDLE;
                default: tx_st_q <= ST_IDLE;
            endcase
        end
    end

    // bus input synchroniser
    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
        end else begin
            rx_s1_q <= bus_in;
            rx_s2_q <= rx_s1_q;
        end
    end

    // receiver: falling edge starts, mid-bit sampling
    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            rx_st_q   <= ST_IDLE;
            rx_ovs_q  <= 4'h0;
            rx_bit_q  <= 3'd0;
            rx_sh_q   <= 8'hFF;
            rx_prev_q <= 1'b1;
        end else if (tick_q) begin
            rx_prev_q <= rx_line;
            rx_ovs_q  <= rx_ovs_q + 4'h1;
            case (rx_st_q)
                ST_IDLE: begin
                    rx_ovs_q <= 4'h0;
                    rx_sh_q  <= 8'hFF;
                    if (rx_prev_q && !rx_line)
                        rx_st_q <= ST_START;
                end
                ST_START: if (rx_ovs_q == 4'h7) begin
                    rx_ovs_q <= 4'h0;
                    rx_bit_q <= 3'd0;
                    rx_st_q  <= rx_line ? ST_IDLE : ST_DATA;
                end
                ST_DATA: if (rx_ovs_q == 4'hF) begin
                    rx_sh_q[rx_bit_q] <= rx_line;
                    rx_bit_q          <= rx_bit_q + 3'd1;
                    if (rx_bit_q == last_bit)
                        rx_st_q <= ST_STOP;
                end
                ST_STOP: if (rx_ovs_q == 4'hF)
                    rx_st_q <= ST_IDLE;
                default: rx_st_q <= ST_IDLE;
            endcase
        end
    end

    assign rx_done = tick_q && rx_st_q == ST_STOP && rx_ovs_q == 4'hF;

    // receive data, ready and error flags; set wins over clear
    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            rbr_q <= 8'hFF;
            dr_q  <= 1'b0;
            oe_q  <= 1'b0;
            fe_q  <= 1'b0;
        end else begin
            if (rx_done) begin
                rbr_q <= rx_sh_q;
                dr_q  <= 1'b1;
                oe_q  <= (oe_q && !lsr_rd) || (dr_q && !rbr_rd);
                fe_q  <= (fe_q && !lsr_rd) || !rx_line;
            end else begin
                // data ready clears on data read
                if (rbr_rd)
                    dr_q <= 1'b0;
                if (lsr_rd) begin
                    oe_q <= 1'b0;
                    fe_q <= 1'b0;
                end
            end
        end
    end

    // read mux, registered
    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                `USWM_OFS_DATA: reg_rdata_out <= div_acc ? div_q[7:0] : rbr_q;
                `USWM_OFS_IER:  reg_rdata_out <= div_acc ? div_q[15:8] : {4'h0, ier_q};
                `USWM_OFS_IIR:  reg_rdata_out <= `USWM_IIR_NONE;
                `USWM_OFS_LCR:  reg_rdata_out <= lcr_q;
                `USWM_OFS_MCR:  reg_rdata_out <= mcr_q;
                `USWM_OFS_LSR:  reg_rdata_out <= {1'b0,
                    cnt_q == 2'd0 && tx_st_q == ST_IDLE, cnt_q != 2'd2,
                    1'b0, fe_q, 1'b0, oe_q, dr_q};
                default:        reg_rdata_out <= 8'h00;
            endcase
        end
    end

    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            term_ready_out     <= 1'b1;
            req_send_out       <= 1'b0;
            aux_output_one_out <= 1'b0;
            aux_output_two_out <= 1'b0;
            ttl_drive_out      <= 1'b0;
        end else begin
            term_ready_out     <= mcr_q[`USWM_MCR_DTR];
            req_send_out       <= mcr_q[`USWM_MCR_RTS];
            aux_output_one_out <= mcr_q[`USWM_MCR_AUX1];
            aux_output_two_out <= mcr_q[`USWM_MCR_AUX2];
            // inverted ttl drive, high pulls bus low
            ttl_drive_out      <= ~tx_line_q & ~loop_en;
        end
    end
endmodule // uswm_master

// ==== verilog/uswm_map.vh ====
/*
 * register offsets, field positions, reset values and timing counts
 * for the serial-port single-wire bus master; definitions only.
 */
`ifndef USWM_MAP_VH
`define USWM_MAP_VH
`define USWM_OFS_DATA      3'h0
`define USWM_OFS_IER       3'h1
`define USWM_OFS_IIR       3'h2
`define USWM_OFS_LCR       3'h3
`define USWM_OFS_MCR       3'h4
`define USWM_OFS_LSR       3'h5
`define USWM_OFS_MSR       3'h6
`define USWM_LCR_DIV_ACC   7
`define USWM_LCR_LEN_HI    1
`define USWM_LCR_LEN_LO    0
`define USWM_MCR_DTR       0
`define USWM_MCR_RTS       1
`define USWM_MCR_AUX1      2
`define USWM_MCR_AUX2      3
`define USWM_MCR_LOOP      4
`define USWM_LSR_DR        0
`define USWM_LSR_OE        1
`define USWM_LSR_FE        3
`define USWM_LSR_HOLD_E    5
`define USWM_LSR_SHIFT_E   6
`define USWM_RST_LCR       8'h03
`define USWM_RST_MCR       8'h01
`define USWM_RST_DIV       16'h000B
`define USWM_IIR_NONE      8'h01
`define USWM_CLK_HZ        40000000
`define USWM_REF_HZ        1843200
`define USWM_OVS           16
`define USWM_RESET_BAUD    10473
`define USWM_SLOT_BAUD     115200
`define USWM_RESET_CHAR    8'hF0
`define USWM_WR0_CHAR      8'h00
`define USWM_WR1_CHAR      8'hFF
`define USWM_BIT_RESET_NS  95500
`define USWM_BIT_SLOT_NS   8680
`endif

// ==== test/uswm_properties.sv ====
/* port properties of uswm_master, bound to every instance.
   assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`include "uswm_map.vh"
module uswm_checker (
    input wire       sys_clk_in,
    input wire       sys_rst_in,
    input wire [2:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire       reg_wr_in,
    input wire       reg_rd_in,
    input wire [7:0] reg_rdata_out,
    input wire       tx_ready_out,
    input wire       bus_in,
    input wire       bus_out,
    input wire       bus_oe_out,
    input wire       ttl_drive_out,
    input wire       term_ready_out,
    input wire       req_send_out,
    input wire       aux_output_one_out,
    input wire       aux_output_two_out
);
    reg       divisor_access_select_q;
    reg [3:0] mcr_q;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    // shadows of the divisor access bit and the last modem write
    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            divisor_access_select_q <= 1'b0;
            mcr_q  <= 4'h1;
        end else if (reg_wr_in && reg_addr_in == `USWM_OFS_LCR) begin
            divisor_access_select_q <= reg_wdata_in[7];
        end else if (reg_wr_in && reg_addr_in == `USWM_OFS_MCR) begin
            mcr_q  <= reg_wdata_in[3:0];
        end
    end
    a_drain_only: assert property (bus_out == 1'b0)
        else $error("bus pin value not zero");
    a_ttl_lag: assert property (ttl_drive_out == $past(bus_oe_out))
        else $error("ttl drive does not follow line");
    a_start_held: assert property ($rose(bus_oe_out) |-> bus_oe_out [*8])
        else $error("start bit too short");
    a_reset_state: assert property ($fell(sys_rst_in) |-> tx_ready_out && !bus_oe_out
        && term_ready_out && reg_rdata_out == 8'h00) else $error("bad state after reset");
    a_rdata_hold: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
        else $error("read data moved without read");
    a_ident_none: assert property (reg_rd_in && reg_addr_in == `USWM_OFS_IIR
        |=> reg_rdata_out == `USWM_IIR_NONE) else $error("ident value wrong");
    a_div_back: assert property (reg_wr_in && reg_addr_in == 3'h0 && divisor_access_select_q
        ##2 reg_rd_in && reg_addr_in == 3'h0 |=> reg_rdata_out == $past(reg_wdata_in, 3))
        else $error("divisor low readback wrong");
    a_len_back: assert property (reg_wr_in && reg_addr_in == `USWM_OFS_LCR
        ##2 reg_rd_in && reg_addr_in == `USWM_OFS_LCR |=> reg_rdata_out == $past(reg_wdata_in, 3))
        else $error("line control readback wrong");
    a_ready_clear: assert property (reg_rd_in && reg_addr_in == 3'h0 && !divisor_access_select_q
        ##2 reg_rd_in && reg_addr_in == `USWM_OFS_LSR |=> !reg_rdata_out[0])
        else $error("data ready not cleared");
    a_modem_pins: assert property (reg_wr_in && reg_addr_in == `USWM_OFS_MCR |-> ##2
        {aux_output_two_out, aux_output_one_out, req_send_out, term_ready_out} == mcr_q)
        else $error("modem pins differ from control");
endmodule // uswm_checker
bind uswm_master uswm_checker chk (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .tx_ready_out(tx_ready_out),
    .bus_in(bus_in), .bus_out(bus_out), .bus_oe_out(bus_oe_out),
    .ttl_drive_out(ttl_drive_out), .term_ready_out(term_ready_out),
    .req_send_out(req_send_out), .aux_output_one_out(aux_output_one_out),
    .aux_output_two_out(aux_output_two_out));

// ==== test/uswm_token.sv ====
/* behavioural memory token on the open-drain bus.
   assumes an external pull-up on the line; delays in ns. */
`timescale 1ns/1ps
module uswm_token (
    input  wire line_in,
    input  wire present_in,
    input  wire bit_in,
    output reg  pull_out,
    output reg  seen_out
);
    time t0;
    initial begin
        pull_out = 1'b0;
        seen_out = 1'b1;
    end
    // one pass per falling edge of the line
    always begin
        @(negedge line_in);
        t0 = $time;
        if (!bit_in) begin
            pull_out = 1'b1;
            #15000 pull_out = 1'b0;
        end
        #(30000 - ($time - t0)) seen_out = line_in;
        if (!line_in) @(posedge line_in);
        if ($time - t0 > 240000 && present_in) begin
            #30000 pull_out = 1'b1;
            #120000 pull_out = 1'b0;
        end
    end
endmodule // uswm_token

// ==== test/test_uswm_master.sv ====
/* bench for uswm_master: registers, bus reset, slots, buffer.
   assumes the token model on the line and default register values. */
`timescale 1ns/1ps
`include "uswm_map.vh"
module test_uswm_master;
    reg        clk = 1'b0, rst = 1'b1, we = 1'b0, re = 1'b0, present = 1'b0, bitv = 1'b1;
    reg  [2:0] addr = 3'h0;
    reg  [7:0] wd = 8'h00, r, s;
    wire [7:0] rdata;
    wire       txr, bo, boe, ttl, dtr, rts, a1, a2, pull, seen;
    wire       line = (boe ? bo : 1'b1) & ~pull;
    integer    fails = 0, n_checks = 0, cyc = 0, oe_n = 0, ttl_n = 0, k, acc;
    always #12.5 clk = ~clk;
    uswm_master uut (.sys_clk_in(clk), .sys_rst_in(rst), .reg_addr_in(addr),
        .reg_wdata_in(wd), .reg_wr_in(we), .reg_rd_in(re), .reg_rdata_out(rdata),
        .tx_ready_out(txr), .bus_in(line), .bus_out(bo), .bus_oe_out(boe),
        .ttl_drive_out(ttl), .term_ready_out(dtr), .req_send_out(rts),
        .aux_output_one_out(a1), .aux_output_two_out(a2));
    uswm_token tok (.line_in(line), .present_in(present), .bit_in(bitv),
        .pull_out(pull), .seen_out(seen));
    // drive-time counters and hang limit
    always @(posedge clk) begin
        cyc = cyc + 1;
        oe_n = oe_n + boe;
        ttl_n = ttl_n + ttl;
        if (cyc == 95000) begin
            fails = fails + 1;
            end_of_test;
        end
    end
    task chk(input [8*10:1] nm, input [15:0] got, input [15:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("[FAIL] %0s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    task wr_reg(input [2:0] a, input [7:0] d);
        begin
            addr = a;
            wd = d;
            we = 1'b1;
            @(posedge clk) #2 we = 1'b0;
            // idle edge so a following strobe rises in a later step
            @(posedge clk) #2;
        end
    endtask
    task rd_reg(input [2:0] a, output [7:0] d);
        begin
            addr = a;
            re = 1'b1;
            @(posedge clk) #2 re = 1'b0;
            d = rdata;
            @(posedge clk) #2;
        end
    endtask
    // poll one status bit, bounded
    task wait_lsr(input integer b);
        begin
            s = 8'h00;
            k = 0;
            while (s[b] !== 1'b1 && k < 50000) begin
                rd_reg(`USWM_OFS_LSR, s);
                k = k + 1;
            end
        end
    endtask
    task slot(input [7:0] c);
        begin
            oe_n = 0;
            ttl_n = 0;
            wr_reg(`USWM_OFS_DATA, c);
            wait_lsr(`USWM_LSR_DR);
            rd_reg(`USWM_OFS_DATA, r);
        end
    endtask
    task end_of_test;
        begin
            $display("checks %0d fails %0d", n_checks, fails);
            if (fails == 0 && n_checks > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    initial begin
        repeat (5) @(posedge clk);
        #2 rst = 1'b0;
        // reset values, ident, unmapped place, divisor window
        rd_reg(`USWM_OFS_LCR, r);
        chk("line ctl", r, `USWM_RST_LCR);
        rd_reg(`USWM_OFS_MCR, r);
        chk("modem ctl", r, `USWM_RST_MCR);
        wr_reg(`USWM_OFS_IIR, 8'h55);
        rd_reg(`USWM_OFS_IIR, r);
        chk("ident", r, `USWM_IIR_NONE);
        rd_reg(3'h7, r);
        chk("unmapped", r, 8'h00);
        wr_reg(`USWM_OFS_LCR, 8'h83);
        rd_reg(`USWM_OFS_LCR, r);
        chk("line ctl", r, 8'h83);
        rd_reg(`USWM_OFS_DATA, r);
        chk("div low", r, 8'h0B);
        rd_reg(`USWM_OFS_IER, r);
        chk("div high", r, 8'h00);
        wr_reg(`USWM_OFS_DATA, 8'hA5);
        rd_reg(`USWM_OFS_DATA, r);
        chk("div low", r, 8'hA5);
        chk("bus idle", boe, 1'h0);
        wr_reg(`USWM_OFS_DATA, 8'h0B);
        wr_reg(`USWM_OFS_MCR, 8'h0F);
        @(posedge clk) #2;
        chk("mcr pins", {a2, a1, rts, dtr}, 4'hF);
        wr_reg(`USWM_OFS_MCR, 8'h01);
        wr_reg(`USWM_OFS_LCR, 8'h03);
        $display("test regs done");
        // bus reset answered by presence
        present = 1'b1;
        slot(`USWM_RESET_CHAR);
        present = 1'b0;
        chk("reset low", oe_n >= 19050 && oe_n <= 19150, 1'h1);
        chk("ttl time", ttl_n, oe_n);
        chk("presence", r, 8'hC0);
        $display("test reset done");
        // data slots at divisor 1, six-bit then eight-bit characters
        wr_reg(`USWM_OFS_LCR, 8'h83);
        wr_reg(`USWM_OFS_DATA, 8'h01);
        wr_reg(`USWM_OFS_LCR, 8'h01);
        slot(`USWM_WR0_CHAR);
        chk("wr0 seen", seen, 1'h0);
        chk("wr0 low", oe_n >= 2400 && oe_n <= 2460, 1'h1);
        chk("wr0 echo", r[5:0], 6'h00);
        rd_reg(`USWM_OFS_LSR, s);
        chk("ready clr", s[0], 1'h0);
        slot(`USWM_WR1_CHAR);
        chk("wr1 seen", seen, 1'h1);
        chk("wr1 low", oe_n >= 40 && oe_n <= 600, 1'h1);
        chk("wr1 echo", r[5:0], 6'h3F);
        bitv = 1'b0;
        slot(`USWM_WR1_CHAR);
        bitv = 1'b1;
        chk("rd zero", r[5:0], 6'h3E);
        wr_reg(`USWM_OFS_LCR, 8'h03);
        slot(`USWM_WR1_CHAR);
        chk("rd one", r, 8'hFF);
        slot(`USWM_RESET_CHAR);
        chk("no slave", r, `USWM_RESET_CHAR);
        $display("test slots done");
        // fill the buffer until refused, then drain
        oe_n = 0;
        acc = 0;
        while (txr === 1'b1 && acc < 5) begin
            wr_reg(`USWM_OFS_DATA, 8'hFF);
            acc = acc + 1;
        end
        chk("full", acc >= 2 && acc <= 3, 1'h1);
        wr_reg(`USWM_OFS_DATA, 8'h00);
        repeat (acc) begin
            wait_lsr(`USWM_LSR_DR);
            rd_reg(`USWM_OFS_DATA, r);
            chk("burst", r, 8'hFF);
        end
        wait_lsr(`USWM_LSR_SHIFT_E);
        chk("refused", oe_n <= acc * 360, 1'h1);
        chk("not full", s[5], 1'h1);
        $display("test buffer done");
        // internal loop: echo comes back without driving the bus
        wr_reg(`USWM_OFS_MCR, 8'h11);
        slot(8'hA5);
        chk("loop echo", r, 8'hA5);
        chk("loop quiet", oe_n + ttl_n, 0);
        wr_reg(`USWM_OFS_MCR, `USWM_RST_MCR);
        $display("test loop done");
        end_of_test;
    end
endmodule // test_uswm_master
